//--- design/pwmc_defs.vh
`ifndef PWMC_DEFS_VH
`define PWMC_DEFS_VH

// ==========================================================
// Register map (byte addresses)
`define PWMC_A_GCFG    8'h00
`define PWMC_A_FREQ    8'h04
`define PWMC_A_PHASE   8'h08
`define PWMC_A_COMP    8'h0C
`define PWMC_A_MODE    8'h10
`define PWMC_A_RUN     8'h14
`define PWMC_A_PAD     8'h18
`define PWMC_A_OVLIM   8'h1C
`define PWMC_A_ISTS    8'h20
`define PWMC_A_IMASK   8'h24

// ==========================================================
// Field positions
`define PWMC_GCFG_MASTER 0
`define PWMC_GCFG_EXTREQ 4
`define PWMC_PAD_EXT     0
`define PWMC_PAD_LINE    1
`define PWMC_PAD_DRV     10
`define PWMC_IRQ_ACQ     0
`define PWMC_IRQ_LOST    1
`define PWMC_IRQ_OV      2
`define PWMC_IRQ_ELECT   3

// ==========================================================
// Reset values
`define PWMC_PER_RST   16'h0190
`define PWMC_PH1_RST   16'h00C8
`define PWMC_COMP_RST  16'h0000
`define PWMC_OVLIM_RST 16'hFFFF

// ==========================================================
// Timing
`define PWMC_CLK_MHZ    200
`define PWMC_PULSE_NS   500
`define PWMC_PULSE_CYC  ((`PWMC_PULSE_NS * `PWMC_CLK_MHZ + 999) / 1000)
`define PWMC_REFR_NS    100
`define PWMC_REFR_CYC   ((`PWMC_REFR_NS * `PWMC_CLK_MHZ + 999) / 1000)
`define PWMC_REFR_DIV   16'h000C
`define PWMC_RAMP_TICKS 8'h40
`define PWMC_DROP_EVERY 2'h2
`define PWMC_RESP_OK    2'h0
`define PWMC_RESP_ERR   2'h2
`endif

//--- design/pwmc_sync2.v
`timescale 1ns/1ps
`include "pwmc_defs.vh"
// ==========================================================
// Two-stage synchroniser for asynchronous inputs.
module pwmc_sync2 #(
  parameter W = 1
) (
  input  wire         aclk,    // Block clock.
  input  wire         aresetn, // Synchronous reset, active low.
  input  wire [W-1:0] d,       // Asynchronous inputs.
  output reg  [W-1:0] q        // Synchronised outputs.
);
  reg [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // pwmc_sync2

//--- design/pwmc_chan.v
`timescale 1ns/1ps
`include "pwmc_defs.vh"
// ==========================================================
// One PWM channel: phase delay, mode sequencing, gate drive.
module pwmc_chan (
  input  wire        aclk,    // Block clock.
  input  wire        aresetn, // Synchronous reset, active low.
  input  wire        run,     // Channel enabled and switching allowed.
  input  wire        dcm_sel, // Discontinuous mode selected.
  input  wire        tick,    // Timing reference pulse.
  input  wire [15:0] phase,   // Set delay in clock cycles.
  input  wire [15:0] rlen,    // Dropout refresh length.
  input  wire        pk,      // Peak current trip, synchronised.
  input  wire        irev,    // Reverse current comparator.
  input  wire        drop,    // Dropout detected.
  output reg         top_on,  // Top switch gate.
  output reg         bot_on,  // Bottom switch gate.
  output reg         ccm,     // Running in continuous conduction.
  output wire        ramping  // Start-up ramp in progress.
);
  reg [15:0] dly_q;
  reg        act_q;
  reg [7:0]  ramp_q;
  reg [1:0]  cyc_q;
  reg [15:0] rcnt_q;
  reg        blank_q;
  reg        rev_q;
  wire       set_p  = (tick && phase == 16'h0000) || (act_q && dly_q == 16'h0001);
  wire       dcm    = (ramp_q != 8'h00) || dcm_sel;
  wire       refr   = set_p && drop && cyc_q == `PWMC_DROP_EVERY;

  assign ramping = ramp_q != 8'h00;

  // Set pulse follows the reference edge by the phase count.
  always @(posedge aclk) begin
    if (!aresetn) begin
      dly_q <= 16'h0000;
      act_q <= 1'b0;
    end else if (tick && phase != 16'h0000) begin
      dly_q <= phase;
      act_q <= 1'b1;
    end else if (act_q) begin
      dly_q <= dly_q - 16'h0001;
      act_q <= dly_q != 16'h0001;
    end
  end

  // Ramp runs discontinuous for a fixed number of periods.
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      ramp_q <= `PWMC_RAMP_TICKS;
      cyc_q  <= 2'h0;
    end else if (set_p) begin
      if (ramp_q != 8'h00)
        ramp_q <= ramp_q - 8'h01;
      cyc_q <= (cyc_q == `PWMC_DROP_EVERY) ? 2'h0 : cyc_q + 2'h1;
    end
  end

  // Gate drive; dropout delays top turn-on every third cycle.
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      top_on  <= 1'b0;
      bot_on  <= 1'b0;
      rcnt_q  <= 16'h0000;
      blank_q <= 1'b0;
      rev_q   <= 1'b0;
      ccm     <= 1'b0;
    end else begin
      if (refr) begin
        rcnt_q <= rlen;
        top_on <= 1'b0;
        bot_on <= 1'b1;
      end else if (rcnt_q == 16'h0001) begin
        rcnt_q <= 16'h0000;
        top_on <= 1'b1;
        bot_on <= 1'b0;
      end else if (rcnt_q != 16'h0000) begin
        rcnt_q <= rcnt_q - 16'h0001;
      end else if (set_p) begin
        top_on <= 1'b1;
        bot_on <= 1'b0;
      end else if (pk && top_on) begin
        top_on <= 1'b0;
        bot_on <= !blank_q;
      end else if (dcm && irev) begin
        bot_on <= 1'b0;
      end
      // Bottom stays off for the rest of the cycle once reverse seen in discontinuous mode.
      if (set_p) begin
        blank_q <= 1'b0;
        rev_q   <= 1'b0;
        ccm     <= !(dcm && rev_q);
      end else if (dcm && irev) begin
        blank_q <= 1'b1;
        rev_q   <= 1'b1;
      end
    end
  end
endmodule // pwmc_chan

//--- design/pwmc_top.v
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pwmc_defs.vh"
// ==========================================================
// Timing reference, sync line, channels and register slave.
module pwmc_top (
  input  wire        aclk,          // Block clock, 200 MHz.
  input  wire        aresetn,       // Synchronous reset, active low.
  input  wire [7:0]  s_axi_awaddr,  // Write address.
  input  wire        s_axi_awvalid, // Write address valid.
  output wire        s_axi_awready, // Write address ready.
  input  wire [31:0] s_axi_wdata,   // Write data.
  input  wire [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire        s_axi_wvalid,  // Write data valid.
  output wire        s_axi_wready,  // Write data ready.
  output reg  [1:0]  s_axi_bresp,   // Write response.
  output reg         s_axi_bvalid,  // Write response valid.
  input  wire        s_axi_bready,  // Write response ready.
  input  wire [7:0]  s_axi_araddr,  // Read address.
  input  wire        s_axi_arvalid, // Read address valid.
  output wire        s_axi_arready, // Read address ready.
  output reg  [31:0] s_axi_rdata,   // Read data.
  output reg  [1:0]  s_axi_rresp,   // Read response.
  output reg         s_axi_rvalid,  // Read data valid.
  input  wire        s_axi_rready,  // Read data ready.
  input  wire        sync_i,        // Timing line level.
  output reg         sync_o,        // Timing line drive value, always low.
  output reg         sync_oe,       // Timing line pull-down enable.
  input  wire [1:0]  pk_trip_i,     // Peak current comparators.
  input  wire [1:0]  i_rev_i,       // Reverse current comparators.
  input  wire [1:0]  dropout_i,     // Dropout detectors.
  input  wire [15:0] adc_vin,       // Measured input voltage.
  input  wire        adc_vin_valid, // New input voltage sample.
  output wire [1:0]  top_on,        // Top gate per channel.
  output wire [1:0]  bot_on,        // Bottom gate per channel.
  output wire [1:0]  ccm_active,    // Continuous conduction per channel.
  output reg  [4:0]  comp0_res,     // Channel 0 resistor code.
  output reg  [2:0]  comp0_gm,      // Channel 0 transconductance.
  output reg  [4:0]  comp1_res,     // Channel 1 resistor code.
  output reg  [2:0]  comp1_gm,      // Channel 1 transconductance.
  output wire        irq            // Interrupt, active high level.
);
  // ========================================================
  // Registers
  reg        master_q, extreq_q;
  reg [15:0] per_q, ph0_q, ph1_q, comp_q, ovlim_q;
  reg [1:0]  mode_q, run_q;
  reg [3:0]  ists_q, imask_q;
  reg        aw_got_q, w_got_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        line_q, ext_seen_q, ext_ok_q, drv_en_q;
  reg [17:0] ext_cnt_q;
  reg [15:0] osc_cnt_q;
  reg [7:0]  pcnt_q;
  wire [6:0] syn;
  wire [1:0] ramp;

  pwmc_sync2 #(.W(7)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({dropout_i, i_rev_i, pk_trip_i, sync_i}),
    .q       (syn)
  );

  // ========================================================
  // Timing line observation
  wire        line_s  = syn[0];
  wire        fall    = line_q && !line_s;
  wire        own     = pcnt_q != 8'h00;
  wire        foreign = fall && !own;
  wire [17:0] lim     = {2'b00, per_q} + {4'h0, per_q[15:2]};
  wire        late    = ext_cnt_q > lim;
  wire        osc_wrap = osc_cnt_q >= per_q - 16'h0001;
  wire        tick    = ext_ok_q ? foreign : osc_wrap;
  wire        sw_ok   = !extreq_q || ext_ok_q;
  wire [31:0] rlen_w  = per_q / `PWMC_REFR_DIV + `PWMC_REFR_CYC;
  wire [15:0] rlen    = rlen_w[15:0];
  wire [31:0] pulse_w = `PWMC_PULSE_CYC;
  wire        any_run = run_q != 2'b00;

  // An edge arriving within 125% of our period means the outside
  // clock runs above 80% of ours; a late one drops the lock.
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_q     <= 1'b1;
      ext_cnt_q  <= 18'h3FFFF;
      ext_seen_q <= 1'b0;
      ext_ok_q   <= 1'b0;
    end else begin
      line_q <= line_s;
      if (foreign)
        ext_cnt_q <= 18'h00000;
      else if (ext_cnt_q != 18'h3FFFF)
        ext_cnt_q <= ext_cnt_q + 18'h00001;
      if (foreign) begin
        ext_seen_q <= 1'b1;
        ext_ok_q   <= ext_seen_q && !late;
      end else if (late) begin
        ext_seen_q <= 1'b0;
        ext_ok_q   <= 1'b0;
      end
    end
  end

  // Internal oscillator; restarts on each followed outside edge.
  always @(posedge aclk) begin
    if (!aresetn || tick)
      osc_cnt_q <= 16'h0000;
    else if (osc_cnt_q != 16'hFFFF)
      osc_cnt_q <= osc_cnt_q + 16'h0001;
  end

  // ========================================================
  // Master drive and election
  // A master that sees a falling edge it did not make has lost
  // the election or found an outside clock, and lets go of the
  // line until that clock goes away. Two masters that fall in
  // the very same cycle both keep driving in step, harmlessly.
  always @(posedge aclk) begin
    if (!aresetn) begin
      drv_en_q <= 1'b0;
      pcnt_q   <= 8'h00;
      sync_oe  <= 1'b0;
      sync_o   <= 1'b0;
    end else begin
      sync_o <= 1'b0;
      if (!master_q || foreign)
        drv_en_q <= 1'b0;
      else if (!ext_seen_q)
        drv_en_q <= 1'b1;
      if (osc_wrap && drv_en_q && master_q && !foreign) begin
        pcnt_q  <= pulse_w[7:0];
        sync_oe <= 1'b1;
      end else if (pcnt_q != 8'h00) begin
        pcnt_q  <= pcnt_q - 8'h01;
        sync_oe <= pcnt_q != 8'h01;
      end else begin
        sync_oe <= 1'b0;
      end
    end
  end

  // ========================================================
  // Channels
  pwmc_chan u_ch0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run_q[0] && sw_ok),
    .dcm_sel (mode_q[0]),
    .tick    (tick),
    .phase   (ph0_q),
    .rlen    (rlen),
    .pk      (syn[1]),
    .irev    (syn[3]),
    .drop    (syn[5]),
    .top_on  (top_on[0]),
    .bot_on  (bot_on[0]),
    .ccm     (ccm_active[0]),
    .ramping (ramp[0])
  );

  pwmc_chan u_ch1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run_q[1] && sw_ok),
    .dcm_sel (mode_q[1]),
    .tick    (tick),
    .phase   (ph1_q),
    .rlen    (rlen),
    .pk      (syn[2]),
    .irev    (syn[4]),
    .drop    (syn[6]),
    .top_on  (top_on[1]),
    .bot_on  (bot_on[1]),
    .ccm     (ccm_active[1]),
    .ramping (ramp[1])
  );

  // ========================================================
  // Register read mux; bit 32 flags a mapped address.
  function [32:0] rd;
    input [7:0] a;
    begin
      rd = {1'b1, 32'h00000000};
      case (a)
        `PWMC_A_GCFG: begin
          rd[`PWMC_GCFG_MASTER] = master_q;
          rd[`PWMC_GCFG_EXTREQ] = extreq_q;
        end
        `PWMC_A_FREQ:  rd[15:0] = per_q;
        `PWMC_A_PHASE: rd[31:0] = {ph1_q, ph0_q};
        `PWMC_A_COMP:  rd[15:0] = comp_q;
        `PWMC_A_MODE:  rd[3:0] = {ramp, mode_q};
        `PWMC_A_RUN:   rd[3:0] = {ccm_active, run_q};
        `PWMC_A_PAD: begin
          rd[`PWMC_PAD_EXT]  = ext_ok_q;
          rd[`PWMC_PAD_LINE] = line_q;
          rd[`PWMC_PAD_DRV]  = drv_en_q;
        end
        `PWMC_A_OVLIM: rd[15:0] = ovlim_q;
        `PWMC_A_ISTS:  rd[3:0] = ists_q;
        `PWMC_A_IMASK: rd[3:0] = imask_q;
        default:       rd[32] = 1'b0;
      endcase
    end
  endfunction

  // ========================================================
  // Write channel and read address handshakes
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
  wire [32:0] cur   = rd(awaddr_q);
  wire [31:0] bm    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wv    = (cur[31:0] & ~bm) | (wdata_q & bm);
  // Frequency and phase are locked while any channel runs.
  wire        lock  = any_run && (awaddr_q == `PWMC_A_FREQ || awaddr_q == `PWMC_A_PHASE);
  wire        wr_ok = do_wr && cur[32] && !lock;
  wire        ov    = adc_vin_valid && adc_vin > ovlim_q;
  wire [3:0]  ev;

  assign ev[`PWMC_IRQ_ACQ]   = foreign && ext_seen_q && !late && !ext_ok_q;
  assign ev[`PWMC_IRQ_LOST]  = !foreign && late && ext_ok_q;
  assign ev[`PWMC_IRQ_OV]    = ov && any_run;
  assign ev[`PWMC_IRQ_ELECT] = foreign && master_q && drv_en_q;
  assign irq = (ists_q & imask_q) != 4'h0;

  // Address and data may arrive in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PWMC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `PWMC_RESP_OK : `PWMC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage. An overvoltage clears the run bits and
  // beats a software write in the same cycle; a status event
  // beats a write-one-to-clear in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      master_q <= 1'b0;
      extreq_q <= 1'b0;
      per_q    <= `PWMC_PER_RST;
      ph0_q    <= 16'h0000;
      ph1_q    <= `PWMC_PH1_RST;
      comp_q   <= `PWMC_COMP_RST;
      mode_q   <= 2'b00;
      run_q    <= 2'b00;
      ovlim_q  <= `PWMC_OVLIM_RST;
      ists_q   <= 4'h0;
      imask_q  <= 4'h0;
    end else begin
      if (wr_ok) begin
        case (awaddr_q)
          `PWMC_A_GCFG: begin
            master_q <= wv[`PWMC_GCFG_MASTER];
            extreq_q <= wv[`PWMC_GCFG_EXTREQ];
          end
          `PWMC_A_FREQ:  per_q <= wv[15:0];
          `PWMC_A_PHASE: {ph1_q, ph0_q} <= wv;
          `PWMC_A_COMP:  comp_q <= wv[15:0];
          `PWMC_A_MODE:  mode_q <= wv[1:0];
          `PWMC_A_RUN:   run_q <= wv[1:0];
          `PWMC_A_OVLIM: ovlim_q <= wv[15:0];
          `PWMC_A_IMASK: imask_q <= wv[3:0];
          default: ;
        endcase
      end
      if (ov)
        run_q <= 2'b00;
      ists_q <= (ists_q & ~((wr_ok && awaddr_q == `PWMC_A_ISTS) ? wv[3:0] : 4'h0)) | ev;
    end
  end

  // Compensation fields drive the analog loop through one register stage.
  always @(posedge aclk) begin
    if (!aresetn) begin
      comp0_res <= 5'h00;
      comp0_gm  <= 3'h0;
      comp1_res <= 5'h00;
      comp1_gm  <= 3'h0;
    end else begin
      comp0_res <= comp_q[4:0];
      comp0_gm  <= comp_q[7:5];
      comp1_res <= comp_q[12:8];
      comp1_gm  <= comp_q[15:13];
    end
  end

  wire [32:0] rd_a = rd({s_axi_araddr[7:2], 2'b00});

  // Read channel answers one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PWMC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_a[31:0];
      s_axi_rresp  <= rd_a[32] ? `PWMC_RESP_OK : `PWMC_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pwmc_top

//--- tb/pwmc_peer.sv
`timescale 1ns/1ps
// ==================================================
// Another regulator clocking the shared timing line.
module pwmc_peer (
  input  wire en,  // Clock the line while high.
  output reg  pull // High while pulling the line low.
);
  // A 125 ns square wave at half duty, started off the block's clock grid.
  // Released between bursts so the pull-up holds the line high.
  initial begin
    pull = 1'b0;
    forever begin
      wait (en);
      #1.3;
      while (en) begin
        pull = 1'b1;
        #62.5;
        pull = 1'b0;
        #62.5;
      end
    end
  end
endmodule // pwmc_peer

//--- tb/pwmc_sva.sv
`timescale 1ns/1ps
// ==================================================
// Port checks for the register bus, timing line and gate drives.
module pwmc_sva (
  input wire        aclk,          // Block clock.
  input wire        aresetn,       // Reset, active low.
  input wire        s_axi_awvalid, // Write address valid.
  input wire        s_axi_awready, // Write address ready.
  input wire        s_axi_wvalid,  // Write data valid.
  input wire        s_axi_wready,  // Write data ready.
  input wire [1:0]  s_axi_bresp,   // Write response.
  input wire        s_axi_bvalid,  // Write response valid.
  input wire        s_axi_bready,  // Write response ready.
  input wire        s_axi_arvalid, // Read address valid.
  input wire        s_axi_arready, // Read address ready.
  input wire [31:0] s_axi_rdata,   // Read data.
  input wire        s_axi_rvalid,  // Read data valid.
  input wire        s_axi_rready,  // Read data ready.
  input wire        sync_i,        // Timing line level.
  input wire        sync_oe,       // Timing line pull-down.
  input wire [1:0]  top_on,        // Top gates.
  input wire [1:0]  bot_on         // Bottom gates.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [7:0] low_q; // Cycles of the current pull-down.
  // Saturates, so a stuck driver can never wrap back to a legal width.
  always @(posedge aclk) begin
    if (!aresetn || !sync_oe) low_q <= 8'h00;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
  end
  // A falling edge that this block did not cause, then a quiet window.
  sequence foreign_fall_s;
    ($fell(sync_i) && !sync_oe && !$past(sync_oe)) ##1 !sync_oe [*3];
  endsequence
  sequence quiet_s;
    !sync_oe [*8];
  endsequence
  pulse_width_a: assert property ($fell(sync_oe) |-> low_q == 8'h64)
    else $error("Pull-down width wrong.");
  foreign_yield_a: assert property (foreign_fall_s |-> ##2 quiet_s)
    else $error("Driver kept pulling after a foreign edge.");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write response late.");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read response late.");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped.");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped.");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken while answering.");
  gate_excl_a: assert property ((top_on & bot_on) == 2'b00)
    else $error("Both gates of a channel on.");
endmodule // pwmc_sva

//--- tb/tb.sv
`timescale 1ns/1ps
// ==================================================
// Self-checking bench for the timing and PWM control block.
module tb;
  localparam logic [1:0] OK  = 2'h0; // Accepted.
  localparam logic [1:0] ERR = 2'h2; // Refused.
  logic        aclk;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic [1:0]  pk_trip_i     = 2'h0;
  logic [15:0] adc_vin       = 16'h0;
  logic        adc_vin_valid = 1'b0;
  logic        peer_en       = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, top_on, bot_on, ccm_active;
  wire  [31:0] s_axi_rdata;
  wire  [4:0]  comp0_res, comp1_res;
  wire  [2:0]  comp0_gm, comp1_gm;
  wire         sync_o, sync_oe, irq, peer_pull;
  wire         sync_i = (sync_oe ? sync_o : 1'b1) & ~peer_pull; // Pulled-up open-drain line.
  int          n_errors = 0, cmp_count = 0, n;
  logic [31:0] d;
  logic [1:0]  acc;
  // ==================================================
  // Clock, peak-current feedback and the parts.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // The peak comparator trips one cycle after the top gate turns on.
  always @(posedge aclk) pk_trip_i <= top_on;
  pwmc_peer PEER (.en(peer_en), .pull(peer_pull));
  pwmc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sync_i, .sync_o, .sync_oe, .pk_trip_i, .i_rev_i(2'h0), .dropout_i(2'h0), .adc_vin,
    .adc_vin_valid, .top_on, .bot_on, .ccm_active, .comp0_res, .comp0_gm, .comp1_res, .comp1_gm, .irq);
  // ==================================================
  // Shared tasks; each is entered just after a rising edge.
  task stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = sync_oe;
      1: pick = top_on[0];
      2: pick = top_on[1];
      default: pick = irq;
    endcase
  endfunction
  // Counts edges until the chosen output is sampled at v.
  task wait_on(input int w, input logic v, output int k);
    for (k = 0; k < 3000 && pick(w) !== v; k++) @(posedge aclk);
    if (k == 3000) begin
      n_errors++;
      $display("BAD wait %0d timed out", w);
      stop_test;
    end
  endtask
  // Ready is raised together with valid, before the answer is seen, so the hold checks are never exercised.
  task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    bit aw, w;
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1;
    w = 1;
    for (i = 0; i < 50 && (aw || w); i++) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw = 0;
      end
      if (w && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w = 0;
      end
    end
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) @(posedge aclk);
    if (i == 50) check("write timeout", 0, 1);
    if (i == 50) stop_test;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) break;
    end
    s_axi_arvalid <= 1'b0;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) @(posedge aclk);
    if (i == 50) check("read timeout", 0, 1);
    if (i == 50) stop_test;
    v = s_axi_rdata;
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    axi_rd(a, v, OK);
    check(name, v & m, e);
  endtask
  // ==================================================
  // Scenarios.
  task s_regs;
    rd_chk("freq", 8'h04, 32'hFFFFFFFF, 32'h00000190);
    rd_chk("phase", 8'h08, 32'hFFFFFFFF, 32'h00C80000);
    rd_chk("ovlim", 8'h1C, 32'hFFFFFFFF, 32'h0000FFFF);
    rd_chk("pad_drv", 8'h18, 32'h00000400, 32'h0);
    axi_rd(8'h30, d, ERR);
    check("unmapped", d, 32'h0);
    axi_wr(8'h30, 32'h1, ERR);
  endtask
  task s_master;
    axi_wr(8'h00, 32'h1, OK);
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, n);
    check("width", n, 100);
    wait_on(0, 1'b1, n);
    check("gap", n, 300);
    rd_chk("pad_drv", 8'h18, 32'h00000400, 32'h00000400);
  endtask
  task s_follow;
    axi_wr(8'h24, 32'h8, OK);
    axi_wr(8'h14, 32'h1, OK);
    peer_en <= 1'b1;
    wait_on(3, 1'b1, n);
    repeat (60) @(posedge aclk);
    rd_chk("pad_lock", 8'h18, 32'h00000401, 32'h00000001);
    peer_en <= 1'b0;
    repeat (600) @(posedge aclk);
    rd_chk("pad_lost", 8'h18, 32'h00000401, 32'h00000400);
    rd_chk("ists", 8'h20, 32'h0000000B, 32'h0000000B);
    wait_on(1, 1'b1, n);
    axi_wr(8'h20, 32'h8, OK);
    check("irq_clr", {31'h0, irq}, 32'h0);
  endtask
  task s_phase;
    axi_wr(8'h14, 32'h0, OK);
    axi_wr(8'h08, 32'h003C000A, OK);
    axi_wr(8'h14, 32'h3, OK);
    axi_wr(8'h04, 32'h00000190, ERR);
    axi_wr(8'h08, 32'h0, ERR);
    rd_chk("phase", 8'h08, 32'hFFFFFFFF, 32'h003C000A);
    rd_chk("ramping", 8'h10, 32'hC, 32'hC);
    wait_on(1, 1'b0, n);
    wait_on(1, 1'b1, n);
    wait_on(2, 1'b1, n);
    check("phase_gap", n, 50);
    axi_wr(8'h0C, 32'h0000A5C3, OK);
    @(posedge aclk);
    @(posedge aclk);
    check("comp", {16'h0, comp1_gm, comp1_res, comp0_gm, comp0_res}, 32'h0000A5C3);
  endtask
  task s_extreq;
    axi_wr(8'h14, 32'h0, OK);
    axi_wr(8'h00, 32'h10, OK);
    axi_wr(8'h14, 32'h3, OK);
    acc = 2'h0;
    repeat (800) begin
      @(posedge aclk);
      acc = acc | top_on;
    end
    check("no_ext", {30'h0, acc}, 32'h0);
    peer_en <= 1'b1;
    wait_on(1, 1'b1, n);
    peer_en <= 1'b0;
  endtask
  task s_ov;
    axi_wr(8'h24, 32'h4, OK);
    check("irq_mask", {31'h0, irq}, 32'h0);
    adc_vin <= 16'h0900;
    axi_wr(8'h1C, 32'h00000800, OK);
    adc_vin_valid <= 1'b1;
    @(posedge aclk);
    adc_vin_valid <= 1'b0;
    @(posedge aclk);
    rd_chk("run_ov", 8'h14, 32'h3, 32'h0);
    check("irq_ov", {31'h0, irq}, 32'h1);
    axi_wr(8'h20, 32'h4, OK);
    check("irq_clr", {31'h0, irq}, 32'h0);
  endtask
  // Main sequence: reset held five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_regs;
    s_master;
    s_follow;
    s_phase;
    s_extreq;
    s_ov;
    stop_test;
  end
endmodule // tb
bind pwmc_top pwmc_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .sync_i, .sync_oe, .top_on, .bot_on);
